// >>> src/spdet_top.sv
// setpoint detection and output update block with avalon-mm register slave
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "spdet_map.svh"

// How it works
// - each setpoint holds a sixteen-bit high limit and low limit
// - inside: true when sample below high and above low, strictly
// - outside: true when sample above high or below low
// - greater: true when sample above low limit, high ignored
// - less: true when sample below high limit, low ignored
// - equal: true only when sample equals high limit
// - hysteresis: above high forces value one, below low forces value two
// - hysteresis: samples between limits leave the output unchanged
// - update modes: true only, true and false, or none
// - true-and-false mode applies a second stored value when false
// - port action writes stored byte only where the stored mask selects
// - analog action writes sixteen-bit value to one of four outputs
// - timer action loads stored value into selected timer output
// - only samples entering the scan stream are evaluated
// - a setpoint may compare the lower half of a counter
// - match flag is high while the sample meets the criterion
// - evaluation starts as soon as the acquisition is armed
// - any number of setpoints may share a channel, sixteen in total
// - a match flag changes at most once per scan
// - simultaneous updates: the highest-numbered firing setpoint wins the output
module spdet_top #(
  parameter int NUM_SP   = 16,
  parameter int NUM_AOUT = 4,
  parameter int NUM_TMR  = 4
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic                 sample_valid,
  input  wire logic [5:0]           sample_channel,
  input  wire logic                 sample_is_counter_low,
  input  wire logic [15:0]          sample_data,
  output logic      [NUM_SP-1:0]    channel_match_flag,
  output logic      [7:0]           parallel_digital_out_port,
  output logic                      port_drive_en,
  output logic      [16*NUM_AOUT-1:0] analog_output_channel,
  output logic      [NUM_AOUT-1:0]  analog_output_load,
  output logic      [16*NUM_TMR-1:0] timer_output_channel,
  output logic      [NUM_TMR-1:0]   timer_output_load
);

  // ************************************************************
  // configuration storage
  // ************************************************************
  logic [15:0] high_q      [NUM_SP];
  logic [15:0] low_q       [NUM_SP];
  logic [16:0] cfg_q       [NUM_SP];
  logic [15:0] val_true_q  [NUM_SP];
  logic [15:0] val_false_q [NUM_SP];
  logic [6:0]  src_q       [NUM_SP];
  logic        armed_q;
  logic        busy_q;
  spdet_pkg::spdet_bus_type bus_q;

  // bus decode
  // a write lands at the edge where the master sees waitrequest low
  logic       wr_hit;
  logic [3:0] sp_idx;
  logic [3:0] sp_reg;
  assign wr_hit = (bus_q == spdet_pkg::SPDET_BUS_ACK) && avs_write;
  assign sp_idx = avs_address[6:3];
  assign sp_reg = {1'b0, avs_address[2:0]};

  // avalon slave: every access takes one waitrequest cycle, answered in the next
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_q           <= spdet_pkg::SPDET_BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      case (bus_q)
        spdet_pkg::SPDET_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q           <= spdet_pkg::SPDET_BUS_ACK;
            avs_waitrequest <= 1'b0;
          end else begin
            avs_waitrequest <= 1'b1;
          end
        end
        spdet_pkg::SPDET_BUS_ACK: begin
          bus_q           <= spdet_pkg::SPDET_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_q           <= spdet_pkg::SPDET_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // read mux, registered while the answer is prepared
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (bus_q == spdet_pkg::SPDET_BUS_IDLE && avs_read) begin
      avs_readdata <= 32'h0;
      if (!avs_address[7] && avs_address[2:0] <= 3'h5) begin
        case (sp_reg)
          `SPDET_REG_HIGH:      avs_readdata <= {16'h0, high_q[sp_idx]};
          `SPDET_REG_LOW:       avs_readdata <= {16'h0, low_q[sp_idx]};
          `SPDET_REG_CFG:       avs_readdata <= {15'h0, cfg_q[sp_idx]};
          `SPDET_REG_VAL_TRUE:  avs_readdata <= {16'h0, val_true_q[sp_idx]};
          `SPDET_REG_VAL_FALSE: avs_readdata <= {16'h0, val_false_q[sp_idx]};
          `SPDET_REG_SRC:       avs_readdata <= {25'h0, src_q[sp_idx]};
          default:              avs_readdata <= 32'h0;
        endcase
      end else begin
        case (avs_address)
          `SPDET_GLB_CTRL:  avs_readdata <= {31'h0, armed_q};
          `SPDET_GLB_FLAGS: avs_readdata <= {{(32-NUM_SP){1'b0}}, channel_match_flag};
          `SPDET_GLB_PORT:  avs_readdata <= {23'h0, port_drive_en, parallel_digital_out_port};
          default:          avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  // setpoint configuration writes, only accepted while disarmed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_SP; i++) begin
        high_q[i]      <= `SPDET_RST_HIGH;
        low_q[i]       <= `SPDET_RST_LOW;
        cfg_q[i]       <= 17'h0;
        val_true_q[i]  <= 16'h0;
        val_false_q[i] <= 16'h0;
        src_q[i]       <= 7'h0;
      end
    end else if (wr_hit && !armed_q && !avs_address[7]) begin
      case (sp_reg)
        `SPDET_REG_HIGH:      high_q[sp_idx]      <= avs_writedata[15:0];
        `SPDET_REG_LOW:       low_q[sp_idx]       <= avs_writedata[15:0];
        `SPDET_REG_CFG:       cfg_q[sp_idx]       <= avs_writedata[16:0];
        `SPDET_REG_VAL_TRUE:  val_true_q[sp_idx]  <= avs_writedata[15:0];
        `SPDET_REG_VAL_FALSE: val_false_q[sp_idx] <= avs_writedata[15:0];
        `SPDET_REG_SRC:       src_q[sp_idx]       <= avs_writedata[6:0];
        default: ;
      endcase
    end
  end

  // arm control; evaluation runs from the arm write onward
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_q <= 1'b0;
    end else if (wr_hit && avs_address == `SPDET_GLB_CTRL) begin
      armed_q <= avs_writedata[0];
    end
  end

  // ************************************************************
  // compare and update
  // ************************************************************
  logic [NUM_SP-1:0] hit;
  logic [NUM_SP-1:0] cond;
  logic [NUM_SP-1:0] fire;
  logic [15:0]       fire_val [NUM_SP];
  logic [NUM_SP-1:0] hyst_q;

  // criterion evaluation per setpoint on the arriving sample
  always_comb begin
    for (int i = 0; i < NUM_SP; i++) begin
      hit[i] = armed_q && sample_valid && cfg_q[i][`SPDET_CFG_EN_BIT]
               && (sample_channel == src_q[i][5:0])
               && (sample_is_counter_low == src_q[i][6]);
      case (spdet_pkg::spdet_crit_type'(cfg_q[i][`SPDET_CFG_CRIT_LSB +: 3]))
        spdet_pkg::SPDET_CRIT_INSIDE:
          cond[i] = sample_data < high_q[i] && sample_data > low_q[i];
        spdet_pkg::SPDET_CRIT_OUTSIDE:
          cond[i] = sample_data > high_q[i] || sample_data < low_q[i];
        spdet_pkg::SPDET_CRIT_GREATER:
          cond[i] = sample_data > low_q[i];
        spdet_pkg::SPDET_CRIT_LESS:
          cond[i] = sample_data < high_q[i];
        spdet_pkg::SPDET_CRIT_EQUAL:
          cond[i] = sample_data == high_q[i];
        spdet_pkg::SPDET_CRIT_HYST:
          cond[i] = sample_data > high_q[i] ? 1'b1 :
                    sample_data < low_q[i]  ? 1'b0 : hyst_q[i];
        default:
          cond[i] = 1'b0;
      endcase
      // update decision: hysteresis forces, otherwise per mode
      fire_val[i] = cond[i] ? val_true_q[i] : val_false_q[i];
      if (cfg_q[i][`SPDET_CFG_CRIT_LSB +: 3] == 3'h5) begin
        fire[i] = hit[i] && (sample_data > high_q[i] || sample_data < low_q[i]);
      end else begin
        case (spdet_pkg::spdet_mode_type'(cfg_q[i][`SPDET_CFG_MODE_LSB +: 2]))
          spdet_pkg::SPDET_MODE_TRUE:      fire[i] = hit[i] && cond[i];
          spdet_pkg::SPDET_MODE_TRUEFALSE: fire[i] = hit[i];
          default:                         fire[i] = 1'b0;
        endcase
      end
    end
  end

  // match flags and hysteresis state, updated only on the channel's sample
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channel_match_flag <= '0;
      hyst_q             <= '0;
    end else begin
      for (int i = 0; i < NUM_SP; i++) begin
        if (hit[i]) begin
          channel_match_flag[i] <= cond[i];
          hyst_q[i]             <= cond[i];
        end
      end
    end
  end

  // output ports; a later sample overwrites, and on one sample the highest-numbered firing setpoint wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      parallel_digital_out_port <= `SPDET_RST_PORT;
      port_drive_en             <= 1'b0;
      analog_output_channel     <= '0;
      analog_output_load        <= '0;
      timer_output_channel      <= '0;
      timer_output_load         <= '0;
    end else begin
      analog_output_load <= '0;
      timer_output_load  <= '0;
      if (wr_hit && avs_address == `SPDET_GLB_INIT) begin
        parallel_digital_out_port <= avs_writedata[7:0];
        port_drive_en             <= 1'b1;
      end
      for (int i = 0; i < NUM_SP; i++) begin
        if (fire[i]) begin
          case (spdet_pkg::spdet_act_type'(cfg_q[i][`SPDET_CFG_ACT_LSB +: 2]))
            spdet_pkg::SPDET_ACT_PORT: begin
              for (int b = 0; b < 8; b++) begin
                if (fire_val[i][`SPDET_VAL_MASK_LSB + b]) begin
                  parallel_digital_out_port[b] <= fire_val[i][b];
                end
              end
            end
            spdet_pkg::SPDET_ACT_ANALOG: begin
              for (int a = 0; a < NUM_AOUT; a++) begin
                if (cfg_q[i][`SPDET_CFG_SEL_LSB +: 2] == 2'(a)) begin
                  analog_output_channel[16*a +: 16] <= fire_val[i];
                  analog_output_load[a]             <= 1'b1;
                end
              end
            end
            spdet_pkg::SPDET_ACT_TIMER: begin
              for (int t = 0; t < NUM_TMR; t++) begin
                if (cfg_q[i][`SPDET_CFG_SEL_LSB +: 2] == 2'(t)) begin
                  timer_output_channel[16*t +: 16] <= fire_val[i];
                  timer_output_load[t]             <= 1'b1;
                end
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  mode_none_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (hit[3] && cfg_q[3][5:4] == 2'h0 && cfg_q[3][2:0] != 3'h5) |-> !fire[3])
    else $error("mode none fired an update");

  flag_follows_a: assert property (@(posedge clk) disable iff (rst)
    hit[0] |=> channel_match_flag[0] == $past(cond[0]))
    else $error("match flag did not follow condition");

  flag_holds_a: assert property (@(posedge clk) disable iff (rst)
    !hit[0] |=> $stable(channel_match_flag[0]))
    else $error("match flag changed without a sample");

  inside_cond_a: assert property (@(posedge clk) disable iff (rst)
    (cfg_q[0][2:0] == 3'h0 && sample_data == high_q[0]) |-> !cond[0])
    else $error("inside window true at high limit");

  equal_cond_a: assert property (@(posedge clk) disable iff (rst)
    (cfg_q[0][2:0] == 3'h4) |-> cond[0] == (sample_data == high_q[0]))
    else $error("equal criterion wrong");

  hyst_hold_a: assert property (@(posedge clk) disable iff (rst)
    (hit[1] && cfg_q[1][2:0] == 3'h5 && sample_data <= high_q[1] && sample_data >= low_q[1])
      |-> !fire[1])
    else $error("hysteresis updated inside window");

  disarmed_idle_a: assert property (@(posedge clk) disable iff (rst)
    !armed_q |-> hit == '0)
    else $error("evaluation while disarmed");

  analog_load_a: assert property (@(posedge clk) disable iff (rst)
    (fire[1] && $onehot(fire) && cfg_q[1][9:8] == 2'h2 && cfg_q[1][13:12] == 2'h2)
      |=> analog_output_load[2] && analog_output_channel[47:32] == $past(fire_val[1]))
    else $error("analog output not loaded");

  // output actions, hysteresis forcing, bus behaviour and true-only mode
  port_mask_a: assert property (@(posedge clk) disable iff (rst)
    (fire[0] && $onehot(fire) && !wr_hit && cfg_q[0][9:8] == 2'h1)
      |=> parallel_digital_out_port == (($past(parallel_digital_out_port) & ~$past(fire_val[0][15:8]))
                                        | ($past(fire_val[0][7:0]) & $past(fire_val[0][15:8]))))
    else $error("port update ignored the mask");

  timer_load_a: assert property (@(posedge clk) disable iff (rst)
    (fire[2] && $onehot(fire) && cfg_q[2][9:8] == 2'h3 && cfg_q[2][13:12] == 2'h1)
      |=> timer_output_load[1] && timer_output_channel[31:16] == $past(fire_val[2]))
    else $error("timer output not loaded");

  hyst_force_a: assert property (@(posedge clk) disable iff (rst)
    (hit[1] && cfg_q[1][2:0] == 3'h5 && sample_data > high_q[1]) |=> channel_match_flag[1] && hyst_q[1])
    else $error("hysteresis not forced above high limit");

  armed_refuse_a: assert property (@(posedge clk) disable iff (rst)
    (wr_hit && armed_q && !avs_address[7] && sp_reg == `SPDET_REG_HIGH)
      |=> high_q[$past(sp_idx)] == $past(high_q[sp_idx]))
    else $error("limit written while armed");

  bus_answer_a: assert property (@(posedge clk) disable iff (rst)
    (bus_q == spdet_pkg::SPDET_BUS_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle long");

  mode_true_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (hit[2] && cfg_q[2][5:4] == 2'h1 && cfg_q[2][2:0] != 3'h5 && !cond[2]) |-> !fire[2])
    else $error("true-only mode fired on a false result");

endmodule
`default_nettype wire

// >>> src/spdet_map.svh
// register offsets, field positions and reset values of the setpoint block
`ifndef SPDET_MAP_SVH
`define SPDET_MAP_SVH

// ************************************************************
// register map (setpoint word = index * 8 + register, globals from 8'h80)
// ************************************************************
`define SPDET_REG_HIGH      4'h0
`define SPDET_REG_LOW       4'h1
`define SPDET_REG_CFG       4'h2
`define SPDET_REG_VAL_TRUE  4'h3
`define SPDET_REG_VAL_FALSE 4'h4
`define SPDET_REG_SRC       4'h5
`define SPDET_GLB_CTRL      8'h80
`define SPDET_GLB_FLAGS     8'h84
`define SPDET_GLB_PORT      8'h88
`define SPDET_GLB_INIT      8'h8c

// ************************************************************
// cfg register fields
// ************************************************************
`define SPDET_CFG_CRIT_LSB  0
`define SPDET_CFG_MODE_LSB  4
`define SPDET_CFG_ACT_LSB   8
`define SPDET_CFG_SEL_LSB   12
`define SPDET_CFG_EN_BIT    16

// ************************************************************
// value register fields (port action: data in 7:0, mask in 15:8)
// ************************************************************
`define SPDET_VAL_MASK_LSB  8

// ************************************************************
// reset values
// ************************************************************
`define SPDET_RST_HIGH      16'hffff
`define SPDET_RST_LOW       16'h0000
`define SPDET_RST_PORT      8'h00

`endif

// >>> src/spdet_pkg.sv
// types shared by the setpoint detect block
package spdet_pkg;

  // compare criteria
  typedef enum logic [2:0] {
    SPDET_CRIT_INSIDE  = 3'h0,
    SPDET_CRIT_OUTSIDE = 3'h1,
    SPDET_CRIT_GREATER = 3'h2,
    SPDET_CRIT_LESS    = 3'h3,
    SPDET_CRIT_EQUAL   = 3'h4,
    SPDET_CRIT_HYST    = 3'h5
  } spdet_crit_type;

  // update modes
  typedef enum logic [1:0] {
    SPDET_MODE_NONE      = 2'h0,
    SPDET_MODE_TRUE      = 2'h1,
    SPDET_MODE_TRUEFALSE = 2'h2
  } spdet_mode_type;

  // output actions
  typedef enum logic [1:0] {
    SPDET_ACT_NONE   = 2'h0,
    SPDET_ACT_PORT   = 2'h1,
    SPDET_ACT_ANALOG = 2'h2,
    SPDET_ACT_TIMER  = 2'h3
  } spdet_act_type;

  // bus slave states
  typedef enum logic [1:0] {
    SPDET_BUS_IDLE,
    SPDET_BUS_ACK
  } spdet_bus_type;

endpackage

// >>> tb/spdet_scan_model.sv
// scan sequencer model that feeds the sample stream of the setpoint block
`timescale 1ns/1ps
`default_nettype none

module spdet_scan_model (
  input  wire logic        clk,
  output logic             sample_valid,
  output logic [5:0]       sample_channel,
  output logic             sample_is_counter_low,
  output logic [15:0]      sample_data
);
  // stream idle at time zero
  initial begin
    sample_valid = 1'b0;
    sample_channel = 6'h00;
    sample_is_counter_low = 1'b0;
    sample_data = 16'h0000;
  end

  // one latched scan value as a single-cycle pulse
  task automatic send(input logic [5:0] ch, input logic lo, input logic [15:0] d);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_channel <= ch;
    sample_is_counter_low <= lo; // lower counter half
    sample_data <= d;
    @(posedge clk);
    sample_valid <= 1'b0;
    sample_channel <= ~ch; // stale channel and data do not hold their value
    sample_data <= ~d;
  endtask
endmodule

`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench of the setpoint detect block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clk;
  logic        rst;
  logic        avs_read;
  logic        avs_write;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        sample_valid;
  logic        sample_is_counter_low;
  logic [5:0]  sample_channel;
  logic [15:0] sample_data;
  logic [15:0] channel_match_flag;
  logic [7:0]  parallel_digital_out_port;
  logic        port_drive_en;
  logic [63:0] analog_output_channel;
  logic [63:0] timer_output_channel;
  logic [3:0]  analog_output_load;
  logic [3:0]  timer_output_load;
  logic [31:0] rd;
  logic [7:0]  port_exp;
  int          fail_count;
  int          total_checks;

  // clock of 10 ns
  initial clk = 1'b0;
  always #5 clk = ~clk;

  spdet_top DUT (
    .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .sample_valid, .sample_channel, .sample_is_counter_low, .sample_data,
    .channel_match_flag, .parallel_digital_out_port, .port_drive_en, .analog_output_channel,
    .analog_output_load, .timer_output_channel, .timer_output_load
  );

  spdet_scan_model u_seq (
    .clk, .sample_valid, .sample_channel, .sample_is_counter_low, .sample_data
  );

  // compare and count
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic stop_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one avalon cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) begin
      fail_count++;
      stop_test();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // arm or disarm the acquisition
  task automatic arm(input logic on);
    bus(1'b1, 8'h80, {31'h0, on});
  endtask

  // cfg word: enable, select, action, mode, criterion
  function automatic logic [31:0] cw(input logic [2:0] c, input logic [1:0] m, a, s);
    return {15'h0, 1'b1, 2'h0, s, 2'h0, a, 2'h0, m, 1'h0, c};
  endfunction

  // program one setpoint while disarmed
  task automatic setsp(input int i, input logic [15:0] hi, lo, input logic [31:0] cfg, vt, vf, src);
    logic [7:0] b;
    b = 8'(i * 8); // setpoint words at index * 8 plus register number
    arm(1'b0);
    bus(1'b1, b, {16'h0, hi});
    bus(1'b1, b + 8'h01, {16'h0, lo});
    bus(1'b1, b + 8'h02, cfg);
    bus(1'b1, b + 8'h03, vt);
    bus(1'b1, b + 8'h04, vf);
    bus(1'b1, b + 8'h05, src);
    arm(1'b1);
  endtask

  // expected outcome of a criterion, unsigned compare
  function automatic logic crit(input int c, input logic [15:0] s, hi, lo);
    case (c)
      0: return s < hi && s > lo;
      1: return s > hi || s < lo;
      2: return s > lo;
      3: return s < hi;
      default: return s == hi;
    endcase
  endfunction

  // reset values, limits and an unmapped word
  task automatic s_reset();
    chk(channel_match_flag, 16'h0000);
    chk({port_drive_en, parallel_digital_out_port}, 9'h000);
    chk(avs_waitrequest, 1'b1);
    bus(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0000ffff);
    bus(1'b0, 8'h01, 32'h0);
    chk(rd, 32'h00000000);
    bus(1'b0, 8'h07, 32'h0);
    chk(rd, 32'h00000000);
  endtask

  // five criteria at the limit boundaries, port update on true and false
  task automatic s_crit();
    logic [15:0] sv [5] = '{16'h0031, 16'h0032, 16'h004b, 16'h0064, 16'h0065};
    logic f;
    bus(1'b1, 8'h8c, 32'h00000081);
    port_exp = 8'h81;
    // channel 1 stands for a digital input source, so equal is allowed there
    for (int c = 0; c < 5; c++) begin
      setsp(0, 16'h0064, 16'h0032, cw(3'(c), 2'h2, 2'h1, 2'h0), 32'h0fa5, 32'hf03c, 32'h01);
      foreach (sv[k]) begin
        u_seq.send(6'h01, 1'b0, sv[k]);
        #1;
        f = crit(c, sv[k], 16'h0064, 16'h0032);
        port_exp = f ? ((port_exp & 8'hf0) | 8'h05) : ((port_exp & 8'h0f) | 8'h30);
        chk(channel_match_flag[0], f);
        chk(parallel_digital_out_port, port_exp);
      end
    end
    chk(port_drive_en, 1'b1);
  endtask

  // hysteresis to analog output 2, no change inside the window
  task automatic s_hyst();
    logic [15:0] sv [4] = '{16'h00fa, 16'h0096, 16'h0032, 16'h0096};
    logic [15:0] ev [4] = '{16'h7000, 16'h7000, 16'h3000, 16'h3000};
    logic [3:0]  ld [4] = '{4'h4, 4'h0, 4'h4, 4'h0};
    setsp(1, 16'h00c8, 16'h0064, cw(3'h5, 2'h1, 2'h2, 2'h2), 32'h7000, 32'h3000, 32'h02);
    foreach (sv[k]) begin
      u_seq.send(6'h02, 1'b0, sv[k]);
      #1;
      chk(analog_output_channel[47:32], ev[k]);
      chk(analog_output_load, ld[k]);
      chk(channel_match_flag[1], k < 2);
    end
  endtask

  // timer action on a lower counter half, true-only mode, mode none
  task automatic s_timer();
    logic [5:0]  ch [4] = '{6'h05, 6'h05, 6'h05, 6'h06};
    logic        lo [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic [15:0] sv [4] = '{16'h000c, 16'h000c, 16'h0020, 16'h0005};
    logic [1:0]  fl [4] = '{2'h0, 2'h1, 2'h0, 2'h2};
    logic [3:0]  ld [4] = '{4'h0, 4'h2, 4'h0, 4'h0};
    setsp(3, 16'hffff, 16'h0000, cw(3'h2, 2'h0, 2'h3, 2'h3), 32'hbeef, 32'hbeef, 32'h06);
    setsp(2, 16'h0010, 16'h0008, cw(3'h0, 2'h1, 2'h3, 2'h1), 32'h1234, 32'h5678, 32'h45);
    foreach (sv[k]) begin
      u_seq.send(ch[k], lo[k], sv[k]);
      #1;
      chk(channel_match_flag[3:2], fl[k] | {k == 3, 1'b0});
      chk(timer_output_load, ld[k]);
      chk(timer_output_channel, k == 0 ? 64'h0 : 64'h12340000);
    end
  endtask

  // writes refused while armed, samples ignored while disarmed
  task automatic s_arm();
    bus(1'b1, 8'h10, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h00000010);
    arm(1'b0);
    u_seq.send(6'h05, 1'b1, 16'h000c);
    #1;
    chk(channel_match_flag[2], 1'b0);
    arm(1'b1);
    u_seq.send(6'h05, 1'b1, 16'h000c);
    #1;
    chk(channel_match_flag[2], 1'b1);
    bus(1'b0, 8'h84, 32'h0);
    chk(rd, 32'h0000000c);
  endtask

  // reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    fail_count = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    s_reset();
    s_crit();
    s_hyst();
    s_timer();
    s_arm();
    stop_test();
  end
endmodule

`default_nettype wire
